// ---- hdl/trs_chan_end.sv ----
// processor side: input buffer, status judgement, recovery, AXI4-Lite registers
//
// Design decisions made here: the placing of the registers and register access over AXI4-Lite.
`timescale 1ns/10ps
`default_nettype none
module trs_chan_end #(
	parameter int BUF_MAX = trs_pkg::BUF_MAX,
	parameter int RETRY_MAX = trs_pkg::RETRY_MAX
) (
	input wire logic clk,
	input wire logic rst_b,
	trs_link.host lnk,
	input wire logic [trs_pkg::AXI_AW-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [trs_pkg::AXI_AW-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready
);
	typedef enum logic [3:0] {
		H_IDLE = 4'h1,
		H_CMD = 4'h2,
		H_RUN = 4'h4,
		H_EVAL = 4'h8
	} trs_hstate_t;
	localparam int WW = trs_pkg::WCNT_W;

	trs_hstate_t state_reg;
	logic back_reg, data_reg, wrec_reg, cur_back_reg, repos_reg;
	logic [WW-1:0] bufsz_reg, words_reg, rd_idx_reg;
	logic [1:0] retry_reg;
	logic [trs_pkg::STAT_W-1:0] stat_reg;
	logic [trs_pkg::WORD_W-1:0] buf_mem [BUF_MAX];
	logic [2:0] cond_reg, act_reg, cond_next, act_next;
	logic [1:0] len_reg, len_next;
	logic aw_hold, w_hold, wr_fire, go;
	logic [trs_pkg::AXI_AW-1:0] awaddr_reg;
	logic [31:0] wdata_reg;
	logic [3:0] wstrb_reg;
	logic lp, eof, late, par, abn, m15_nz, short_blk, len_known, can_retry;

	// ****************************************
	// status judgement
	// ****************************************
	assign lp = stat_reg[trs_pkg::ST_LP];
	assign eof = stat_reg[trs_pkg::ST_EOF];
	assign late = stat_reg[trs_pkg::ST_LATE];
	assign par = stat_reg[trs_pkg::ST_PAR];
	assign abn = stat_reg[trs_pkg::ST_ABN];
	assign m15_nz = (stat_reg[trs_pkg::ST_M15 +: trs_pkg::M15_W] != '0);
	assign short_blk = (len_next != trs_pkg::LEN_LONG);
	assign len_known = !(late && (words_reg <= WW'(trs_pkg::MIN_BUF)));
	assign can_retry = (retry_reg != 2'(RETRY_MAX));

	always_comb begin
		if (words_reg >= WW'(trs_pkg::LONG_WORDS)) len_next = trs_pkg::LEN_LONG;
		else if (words_reg == WW'(trs_pkg::MIN_BUF))
			len_next = m15_nz ? trs_pkg::LEN_MID : trs_pkg::LEN_LONG;
		else len_next = trs_pkg::LEN_SHORT;
	end

	always_comb begin
		cond_next = trs_pkg::C_NONE;
		act_next = trs_pkg::A_NONE;
		if (lp) begin
			cond_next = trs_pkg::C_LP;
			act_next = trs_pkg::A_REPORT_LP;
		end else if (eof) begin
			cond_next = trs_pkg::C_EOF;
			act_next = trs_pkg::A_REPORT_EOF;
		end else if (!cur_back_reg) begin
			if (par) begin
				cond_next = trs_pkg::C_PAR;
				act_next = trs_pkg::A_REPORT_PAR;
			end
		end else if (data_reg) begin
			if (late) begin
				cond_next = trs_pkg::C_LATE;
				act_next = trs_pkg::A_REPORT_LATE;
			end else if (par) begin
				cond_next = trs_pkg::C_PAR;
				act_next = short_blk ? trs_pkg::A_RETRY : trs_pkg::A_REPOS;
			end else if (m15_nz) begin
				cond_next = trs_pkg::C_M15;
				act_next = trs_pkg::A_REPORT_ABN;
			end else if (abn) begin
				cond_next = trs_pkg::C_ABN;
				act_next = trs_pkg::A_REPORT_ABN;
			end
		end else if (par) begin
			cond_next = trs_pkg::C_PAR;
			if (wrec_reg && short_blk) act_next = trs_pkg::A_NONE;
			else if (!len_known) act_next = trs_pkg::A_REPOS;
			else if (short_blk) act_next = trs_pkg::A_RETRY;
			else act_next = trs_pkg::A_NONE;
		end else if (late) begin
			cond_next = trs_pkg::C_LATE;
		end
	end

	// ****************************************
	// read sequencing and recovery
	// ****************************************
	assign go = wr_fire && (awaddr_reg == trs_pkg::OFF_CTRL) && wstrb_reg[0]
		&& wdata_reg[trs_pkg::CTRL_GO] && (state_reg == H_IDLE);

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			state_reg <= H_IDLE;
			cur_back_reg <= 1'b0;
			repos_reg <= 1'b0;
			retry_reg <= 2'h0;
		end else begin
			case (state_reg)
				H_IDLE: if (go) begin
					state_reg <= H_CMD;
					cur_back_reg <= wdata_reg[trs_pkg::CTRL_BACK];
					repos_reg <= 1'b0;
					retry_reg <= 2'h0;
				end
				H_CMD: if (lnk.cmd_ready) state_reg <= H_RUN;
				H_RUN: if (lnk.stat_valid) state_reg <= H_EVAL;
				H_EVAL: begin
					state_reg <= H_IDLE;
					if (repos_reg) begin
						repos_reg <= 1'b0;
						cur_back_reg <= 1'b1;
						state_reg <= H_CMD;
					end else if (can_retry && (act_next == trs_pkg::A_RETRY)) begin
						retry_reg <= retry_reg + 2'h1;
						state_reg <= H_CMD;
					end else if (can_retry && (act_next == trs_pkg::A_REPOS)) begin
						retry_reg <= retry_reg + 2'h1;
						repos_reg <= 1'b1;
						cur_back_reg <= 1'b0;
						state_reg <= H_CMD;
					end
				end
				default: state_reg <= H_IDLE;
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			words_reg <= '0;
			stat_reg <= '0;
			cond_reg <= trs_pkg::C_NONE;
			act_reg <= trs_pkg::A_NONE;
			len_reg <= trs_pkg::LEN_LONG;
		end else begin
			if ((state_reg == H_CMD) && lnk.cmd_ready) words_reg <= '0;
			else if (lnk.word_valid && lnk.word_ready) words_reg <= words_reg + WW'(1);
			if ((state_reg == H_RUN) && lnk.stat_valid) stat_reg <= lnk.stat_word;
			if ((state_reg == H_EVAL) && !repos_reg) begin
				cond_reg <= cond_next;
				act_reg <= act_next;
				len_reg <= len_next;
			end
		end
	end

	// a repositioning pass reads the block but keeps none of its data
	always_ff @(posedge clk) begin
		if (lnk.word_valid && lnk.word_ready && !repos_reg && (words_reg < WW'(BUF_MAX)))
			buf_mem[words_reg[$clog2(BUF_MAX)-1:0]] <= lnk.word_data;
	end

	assign lnk.cmd_valid = (state_reg == H_CMD);
	assign lnk.cmd_back = cur_back_reg;
	assign lnk.word_ready = (state_reg == H_RUN) && (repos_reg || (words_reg < bufsz_reg));
	assign lnk.stat_ready = (state_reg == H_RUN);

	// ****************************************
	// AXI4-Lite register slave
	// ****************************************
	assign s_axi_awready = !aw_hold && !s_axi_bvalid;
	assign s_axi_wready = !w_hold && !s_axi_bvalid;
	assign wr_fire = aw_hold && w_hold;
	assign s_axi_arready = !s_axi_rvalid;

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			aw_hold <= 1'b0;
			w_hold <= 1'b0;
			awaddr_reg <= '0;
			wdata_reg <= '0;
			wstrb_reg <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= trs_pkg::RESP_OKAY;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_hold <= 1'b1;
				awaddr_reg <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_hold <= 1'b1;
				wdata_reg <= s_axi_wdata;
				wstrb_reg <= s_axi_wstrb;
			end
			if (wr_fire) begin
				aw_hold <= 1'b0;
				w_hold <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= ((awaddr_reg == trs_pkg::OFF_CTRL) || (awaddr_reg == trs_pkg::OFF_BUFSZ))
					? trs_pkg::RESP_OKAY : trs_pkg::RESP_SLVERR;
			end else if (s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			back_reg <= 1'b0;
			data_reg <= 1'b1;
			wrec_reg <= 1'b0;
			bufsz_reg <= trs_pkg::BUFSZ_RST;
		end else if (wr_fire && wstrb_reg[0]) begin
			if ((awaddr_reg == trs_pkg::OFF_CTRL) && (state_reg == H_IDLE)) begin
				back_reg <= wdata_reg[trs_pkg::CTRL_BACK];
				data_reg <= wdata_reg[trs_pkg::CTRL_DATA];
				wrec_reg <= wdata_reg[trs_pkg::CTRL_WREC];
			end
			if (awaddr_reg == trs_pkg::OFF_BUFSZ) begin
				if (wdata_reg[WW-1:0] < WW'(trs_pkg::MIN_BUF)) bufsz_reg <= WW'(trs_pkg::MIN_BUF);
				else if (wdata_reg[WW-1:0] > WW'(BUF_MAX)) bufsz_reg <= WW'(BUF_MAX);
				else bufsz_reg <= wdata_reg[WW-1:0];
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= '0;
			s_axi_rresp <= trs_pkg::RESP_OKAY;
			rd_idx_reg <= '0;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rresp <= trs_pkg::RESP_OKAY;
			s_axi_rdata <= '0;
			case (s_axi_araddr)
				trs_pkg::OFF_CTRL: s_axi_rdata <= {28'h0, wrec_reg, data_reg, back_reg, 1'b0};
				trs_pkg::OFF_STATUS: s_axi_rdata <= {8'h0, words_reg, 7'h0, stat_reg};
				trs_pkg::OFF_RESULT: s_axi_rdata <= {19'h0, state_reg != H_IDLE, retry_reg,
					len_reg, cond_reg, act_reg, 2'h0};
				trs_pkg::OFF_DATA: begin
					if (rd_idx_reg < WW'(BUF_MAX))
						s_axi_rdata <= buf_mem[rd_idx_reg[$clog2(BUF_MAX)-1:0]];
					rd_idx_reg <= rd_idx_reg + WW'(1);
				end
				trs_pkg::OFF_BUFSZ: s_axi_rdata <= {24'h0, bufsz_reg};
				default: s_axi_rresp <= trs_pkg::RESP_SLVERR;
			endcase
		end else begin
			if (s_axi_rready) s_axi_rvalid <= 1'b0;
			if (go) rd_idx_reg <= '0;
		end
	end
endmodule
`default_nettype wire

// ---- hdl/trs_pkg.sv ----
// shared constants for the tape block read status link
//
// How it works
// - single frame 000010011 sets end-of-file
// - forward end-of-file block also flags parity error
// - end-of-file may carry abnormal frame count
// - backward lateral or longitudinal fault flags parity
// - lone backward frame other than end-of-file: noise, no data, parity
// - mod-15 field nonzero only if last padded word taken
// - frame count not multiple of 15 sets abnormal
// - buffer at least three words, count accepted words
// - map words and mod-15 field to block length
// - data read priority: lp, eof, late, parity, m15, abnormal
// - backspace priority: lp, eof, parity, late
// - positioning ignores late; short parity block is noise
// - parity plus late, length unknown: forward then backward
// - long parity block for data: forward, retry backward
// - short parity block: discard, reissue backward read
// - write recovery short block: ignore parity error
// - report abnormal count only for data reads
// - pass end-of-file on to requester
package trs_pkg;
	// ****************************************
	// tape frames and words
	// ****************************************
	localparam int FRAME_W = 9;
	localparam int DATA_BITS = 8;
	localparam int FRAMES_PER_WORD = 4;
	localparam int WORD_W = 32;
	localparam int CNT_W = 16;
	localparam int GAP_W = 8;
	localparam int MOD_FRAMES = 15;
	localparam int GAP_FRAMES = 10;
	localparam logic [FRAME_W-1:0] EOF_PATTERN = 9'h013;
	// ****************************************
	// status word layout
	// ****************************************
	localparam int ST_EOF = 0;
	localparam int ST_PAR = 1;
	localparam int ST_LATE = 2;
	localparam int ST_ABN = 3;
	localparam int ST_LP = 4;
	localparam int ST_M15 = 5;
	localparam int M15_W = 4;
	localparam int STAT_W = 9;
	// ****************************************
	// length judgement
	// ****************************************
	localparam int MIN_BUF = 3;
	localparam int LONG_WORDS = 4;
	localparam int BUF_MAX = 8;
	localparam int WCNT_W = 8;
	localparam int RETRY_MAX = 3;
	localparam logic [1:0] LEN_LONG = 2'h0;
	localparam logic [1:0] LEN_MID = 2'h1;
	localparam logic [1:0] LEN_SHORT = 2'h2;
	// ****************************************
	// reported condition and chosen action
	// ****************************************
	localparam logic [2:0] C_NONE = 3'h0;
	localparam logic [2:0] C_LP = 3'h1;
	localparam logic [2:0] C_EOF = 3'h2;
	localparam logic [2:0] C_LATE = 3'h3;
	localparam logic [2:0] C_PAR = 3'h4;
	localparam logic [2:0] C_M15 = 3'h5;
	localparam logic [2:0] C_ABN = 3'h6;
	localparam logic [2:0] A_NONE = 3'h0;
	localparam logic [2:0] A_REPORT_LP = 3'h1;
	localparam logic [2:0] A_REPORT_EOF = 3'h2;
	localparam logic [2:0] A_REPORT_LATE = 3'h3;
	localparam logic [2:0] A_REPORT_PAR = 3'h4;
	localparam logic [2:0] A_REPORT_ABN = 3'h5;
	localparam logic [2:0] A_RETRY = 3'h6;
	localparam logic [2:0] A_REPOS = 3'h7;
	// ****************************************
	// register map and control bits
	// ****************************************
	localparam int AXI_AW = 8;
	localparam logic [7:0] OFF_CTRL = 8'h00;
	localparam logic [7:0] OFF_STATUS = 8'h04;
	localparam logic [7:0] OFF_RESULT = 8'h08;
	localparam logic [7:0] OFF_DATA = 8'h0C;
	localparam logic [7:0] OFF_BUFSZ = 8'h10;
	localparam int CTRL_GO = 0;
	localparam int CTRL_BACK = 1;
	localparam int CTRL_DATA = 2;
	localparam int CTRL_WREC = 3;
	localparam logic [WCNT_W-1:0] BUFSZ_RST = 8'h03;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// ---- hdl/trs_link.sv ----
// link between the tape read end and the processor input channel end
`timescale 1ns/10ps
`default_nettype none
interface trs_link;
	logic cmd_valid;
	logic cmd_ready;
	logic cmd_back;
	logic word_valid;
	logic word_ready;
	logic [trs_pkg::WORD_W-1:0] word_data;
	logic stat_valid;
	logic stat_ready;
	logic [trs_pkg::STAT_W-1:0] stat_word;
	modport dev (
		input cmd_valid, cmd_back, word_ready, stat_ready,
		output cmd_ready, word_valid, word_data, stat_valid, stat_word
	);
	modport host (
		output cmd_valid, cmd_back, word_ready, stat_ready,
		input cmd_ready, word_valid, word_data, stat_valid, stat_word
	);
endinterface
`default_nettype wire

// ---- hdl/trs_tape_end.sv ----
// tape side: frame assembly, block end, status word
`timescale 1ns/10ps
`default_nettype none
module trs_tape_end #(
	parameter int GAP_FRAMES = trs_pkg::GAP_FRAMES,
	parameter int ACK_FRAMES = trs_pkg::FRAMES_PER_WORD
) (
	input wire logic clk,
	input wire logic rst_b,
	trs_link.dev lnk,
	input wire logic frame_tick,
	input wire logic frame_valid,
	input wire logic [trs_pkg::FRAME_W-1:0] frame_data,
	input wire logic lrc_ok,
	input wire logic diag_ok,
	input wire logic load_point,
	output logic tape_run,
	output logic tape_back
);
	typedef enum logic [3:0] {
		D_IDLE = 4'h1,
		D_READ = 4'h2,
		D_DRAIN = 4'h4,
		D_STAT = 4'h8
	} trs_dstate_t;
	localparam int DB = trs_pkg::DATA_BITS;
	localparam int FPW = trs_pkg::FRAMES_PER_WORD;

	trs_dstate_t state_reg;
	logic back_reg, lat_err_reg, late_reg, last_taken_reg, lrc_ok_reg, diag_ok_reg, lp_reg;
	logic wv_reg, sv_reg;
	logic [trs_pkg::WORD_W-1:0] asm_reg, wd_reg;
	logic [1:0] fill_reg;
	logic [trs_pkg::CNT_W-1:0] cnt_reg;
	logic [trs_pkg::GAP_W-1:0] gap_reg;
	logic [trs_pkg::M15_W-1:0] m15_reg;
	logic [trs_pkg::FRAME_W-1:0] first_reg;
	logic [trs_pkg::STAT_W-1:0] stat_reg, stat_next;
	logic take, frame_in, word_done, block_end, single, push, slot_free, drain_out;
	logic is_eof, noise, parity;
	logic [trs_pkg::WORD_W-1:0] push_word;

	// ****************************************
	// frame and word bookkeeping
	// ****************************************
	assign take = wv_reg && lnk.word_ready;
	assign frame_in = (state_reg == D_READ) && frame_valid;
	assign word_done = frame_in && (fill_reg == 2'(FPW - 1));
	assign block_end = (state_reg == D_READ) && !frame_valid && frame_tick
		&& (cnt_reg != '0) && (gap_reg == trs_pkg::GAP_W'(GAP_FRAMES - 1));
	assign single = (cnt_reg == trs_pkg::CNT_W'(1));
	// a lone frame (noise or end-of-file mark) never yields a data word
	assign push = word_done || (block_end && (fill_reg != 2'h0) && !single);
	assign push_word = word_done ? {asm_reg[trs_pkg::WORD_W-DB-1:0], frame_data[DB-1:0]}
		: trs_pkg::WORD_W'(asm_reg << (DB * (FPW - int'(fill_reg))));
	assign slot_free = !wv_reg || take;
	assign drain_out = (state_reg == D_DRAIN) && wv_reg && !take && frame_tick
		&& (gap_reg == trs_pkg::GAP_W'(ACK_FRAMES - 1));

	// ****************************************
	// status composition
	// ****************************************
	assign is_eof = single && (first_reg == trs_pkg::EOF_PATTERN);
	assign noise = back_reg && single && !is_eof;
	assign parity = lat_err_reg || !lrc_ok_reg || noise
		|| (!back_reg && (!diag_ok_reg || is_eof));
	always_comb begin
		stat_next = '0;
		stat_next[trs_pkg::ST_EOF] = is_eof;
		stat_next[trs_pkg::ST_PAR] = parity;
		stat_next[trs_pkg::ST_LATE] = late_reg || drain_out;
		stat_next[trs_pkg::ST_ABN] = (m15_reg != '0);
		stat_next[trs_pkg::ST_LP] = lp_reg;
		// a take in the closing drain cycle is the last word
		stat_next[trs_pkg::ST_M15 +: trs_pkg::M15_W] = (last_taken_reg || take) ? m15_reg : '0;
	end

	// ****************************************
	// sequencing
	// ****************************************
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			state_reg <= D_IDLE;
		end else begin
			case (state_reg)
				D_IDLE: if (lnk.cmd_valid) state_reg <= D_READ;
				D_READ: if (block_end) state_reg <= D_DRAIN;
				D_DRAIN: if (!wv_reg || take || drain_out) state_reg <= D_STAT;
				D_STAT: if (lnk.stat_ready) state_reg <= D_IDLE;
				default: state_reg <= D_IDLE;
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			back_reg <= 1'b0;
			cnt_reg <= '0;
			gap_reg <= '0;
			m15_reg <= '0;
			fill_reg <= 2'h0;
			asm_reg <= '0;
			first_reg <= '0;
			lat_err_reg <= 1'b0;
			lrc_ok_reg <= 1'b1;
			diag_ok_reg <= 1'b1;
			lp_reg <= 1'b0;
		end else if (state_reg == D_IDLE) begin
			if (lnk.cmd_valid) begin
				back_reg <= lnk.cmd_back;
				cnt_reg <= '0;
				gap_reg <= '0;
				m15_reg <= '0;
				fill_reg <= 2'h0;
				asm_reg <= '0;
				lat_err_reg <= 1'b0;
			end
		end else if (frame_in) begin
			cnt_reg <= cnt_reg + trs_pkg::CNT_W'(1);
			m15_reg <= (m15_reg == trs_pkg::M15_W'(trs_pkg::MOD_FRAMES - 1)) ? '0
				: m15_reg + trs_pkg::M15_W'(1);
			gap_reg <= '0;
			fill_reg <= fill_reg + 2'h1;
			asm_reg <= {asm_reg[trs_pkg::WORD_W-DB-1:0], frame_data[DB-1:0]};
			if (cnt_reg == '0) first_reg <= frame_data;
			if (!(^frame_data)) lat_err_reg <= 1'b1;
		end else if (block_end) begin
			gap_reg <= '0;
			lrc_ok_reg <= lrc_ok;
			diag_ok_reg <= diag_ok;
			lp_reg <= load_point;
		end else if (frame_tick && (state_reg != D_STAT)) begin
			gap_reg <= gap_reg + trs_pkg::GAP_W'(1);
		end
	end

	// ****************************************
	// word hand-off and late acknowledge
	// ****************************************
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			wv_reg <= 1'b0;
			wd_reg <= '0;
			late_reg <= 1'b0;
			last_taken_reg <= 1'b0;
		end else begin
			if (push && slot_free) begin
				wv_reg <= 1'b1;
				wd_reg <= push_word;
			end else if (take || drain_out) begin
				wv_reg <= 1'b0;
			end
			if ((state_reg == D_IDLE) && lnk.cmd_valid) late_reg <= 1'b0;
			else if ((push && !slot_free) || drain_out) late_reg <= 1'b1;
			if (push || ((state_reg == D_IDLE) && lnk.cmd_valid)) last_taken_reg <= 1'b0;
			else if (take) last_taken_reg <= 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			sv_reg <= 1'b0;
			stat_reg <= '0;
		end else if ((state_reg == D_DRAIN) && (!wv_reg || take || drain_out)) begin
			sv_reg <= 1'b1;
			stat_reg <= stat_next;
		end else if (lnk.stat_ready) begin
			sv_reg <= 1'b0;
		end
	end

	assign lnk.cmd_ready = (state_reg == D_IDLE);
	assign lnk.word_valid = wv_reg;
	assign lnk.word_data = wd_reg;
	assign lnk.stat_valid = sv_reg;
	assign lnk.stat_word = stat_reg;
	assign tape_run = (state_reg == D_READ);
	assign tape_back = back_reg;
endmodule
`default_nettype wire

// ---- dv/trs_link_props.sv ----
// assertions on the link between the tape end and the channel end
`timescale 1ns/10ps
`default_nettype none
module trs_link_props (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic cmd_valid,
	input wire logic cmd_ready,
	input wire logic cmd_back,
	input wire logic word_valid,
	input wire logic word_ready,
	input wire logic [trs_pkg::WORD_W-1:0] word_data,
	input wire logic stat_valid,
	input wire logic stat_ready,
	input wire logic [trs_pkg::STAT_W-1:0] stat_word
);
	// ****************************************
	// read bookkeeping
	// ****************************************
	logic pend_reg;
	logic back_reg;
	logic [7:0] words_reg;
	logic [3:0] m15;
	assign m15 = stat_word[8:5];
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			pend_reg <= 1'b0;
		end else if (cmd_valid && cmd_ready) begin
			pend_reg <= 1'b1;
		end else if (stat_valid && stat_ready) begin
			pend_reg <= 1'b0;
		end
	end
	always_ff @(posedge clk) begin
		if (cmd_valid && cmd_ready) begin
			back_reg <= cmd_back;
		end
	end
	always_ff @(posedge clk) begin
		if (!rst_b || (cmd_valid && cmd_ready)) begin
			words_reg <= 8'h00;
		end else if (word_valid && word_ready) begin
			words_reg <= words_reg + 8'h01;
		end
	end
	// ****************************************
	// properties
	// ****************************************
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_b);
	sequence stat_take;
		stat_valid && stat_ready;
	endsequence
	sequence stat_wait;
		stat_valid && !stat_ready;
	endsequence
	stat_hold_a: assert property (stat_wait |=> stat_valid && $stable(stat_word))
		else $error("status word dropped or changed while offered");
	one_stat_a: assert property (stat_take |=> !stat_valid [*2])
		else $error("status offered twice for one read");
	stat_pend_a: assert property (stat_valid |-> pend_reg)
		else $error("status offered without a read");
	cmd_idle_a: assert property (cmd_valid && cmd_ready |-> !pend_reg)
		else $error("read accepted before status delivered");
	eof_par_a: assert property (stat_valid && stat_word[0] && !back_reg |-> stat_word[1])
		else $error("forward end-of-file without parity");
	eof_nodata_a: assert property (stat_valid && stat_word[0] |-> words_reg == 8'h00)
		else $error("end-of-file block delivered data");
	m15_range_a: assert property (stat_valid |-> m15 != 4'hF)
		else $error("mod 15 field out of range");
	m15_abn_a: assert property (stat_valid && m15 != 4'h0 |-> stat_word[3])
		else $error("mod 15 nonzero without abnormal count");
	m15_taken_a: assert property (stat_valid && m15 != 4'h0 |-> words_reg != 8'h00)
		else $error("mod 15 nonzero with no word taken");
	word_hold_a: assert property (word_valid && !word_ready |=> !word_valid || $stable(word_data))
		else $error("offered word changed");
endmodule
`default_nettype wire

// ---- dv/test_tape_read_block_status.sv ----
// self-checking bench for both link ends and the register side
`timescale 1ns/10ps
`default_nettype none
module test_tape_read_block_status;
	logic clk = 1'b0, rst_b = 1'b0, frame_tick = 1'b0, frame_valid = 1'b0;
	logic lrc_ok = 1'b1, diag_ok = 1'b1, load_point = 1'b0, tape_run, tape_back;
	logic [8:0] frame_data = 9'h000, one_fr = 9'h000;
	logic [7:0] awaddr = 8'h00, araddr = 8'h00;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic [31:0] wdata = 32'h00000000, rdata, st, rs, rd;
	logic [3:0] wstrb = 4'hF;
	logic [1:0] bresp, rresp, rp;
	logic awready, wready, bvalid, arready, rvalid;
	int mismatches = 0, samples_checked = 0, cyc = 0, blk_len = 0, fi = 0;
	trs_link lnk();
	trs_tape_end i_trs_tape_end (.clk(clk), .rst_b(rst_b), .lnk(lnk.dev),
		.frame_tick(frame_tick), .frame_valid(frame_valid), .frame_data(frame_data),
		.lrc_ok(lrc_ok), .diag_ok(diag_ok), .load_point(load_point),
		.tape_run(tape_run), .tape_back(tape_back));
	trs_chan_end i_trs_chan_end (.clk(clk), .rst_b(rst_b), .lnk(lnk.host),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
	trs_link_props i_trs_link_props (.clk(clk), .rst_b(rst_b), .cmd_valid(lnk.cmd_valid),
		.cmd_ready(lnk.cmd_ready), .cmd_back(lnk.cmd_back), .word_valid(lnk.word_valid),
		.word_ready(lnk.word_ready), .word_data(lnk.word_data), .stat_valid(lnk.stat_valid),
		.stat_ready(lnk.stat_ready), .stat_word(lnk.stat_word));
	always #5 clk = ~clk;
	// ****************************************
	// tape feeder: free-running frame ticks, block frames while the tape runs
	// ****************************************
	function automatic logic [8:0] fr(input int i);
		logic [7:0] d;
		d = 8'h10 + i[7:0];
		if (blk_len == 1) return one_fr;
		return {~^d, d};
	endfunction
	initial forever begin
		repeat (3) begin
			@(posedge clk);
			if (!tape_run) fi = 0;
		end
		frame_tick <= 1'b1;
		frame_valid <= tape_run && (fi < blk_len);
		frame_data <= fr(fi);
		fi = tape_run ? fi + 1 : 0;
		@(posedge clk);
		frame_tick <= 1'b0;
		frame_valid <= 1'b0;
	end
	// ****************************************
	// bus tasks and checking
	// ****************************************
	task automatic stop_test();
		$display("checks %0d mismatches %0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 40000) begin
			mismatches = mismatches + 1;
			stop_test();
		end
	end
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked = samples_checked + 1;
		if (seen !== exp) begin
			mismatches = mismatches + 1;
			$display("ERROR at %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		awaddr <= a;
		awvalid <= 1'b1;
		wdata <= d;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge clk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
		end while (!bvalid);
		bready <= 1'b0;
	endtask
	task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge clk);
			if (arready) arvalid <= 1'b0;
		end while (!rvalid);
		d = rdata;
		r = rresp;
		rready <= 1'b0;
	endtask
	task automatic run(input logic [3:0] ctrl, input int len, input logic [8:0] one,
		input logic [7:0] bsz);
		blk_len = len;
		one_fr = one;
		axi_wr(trs_pkg::OFF_BUFSZ, {24'h000000, bsz});
		axi_wr(trs_pkg::OFF_CTRL, {28'h0000000, ctrl});
		do begin
			axi_rd(trs_pkg::OFF_RESULT, rs, rp);
		end while (rs[12] !== 1'b0);
		axi_rd(trs_pkg::OFF_STATUS, st, rp);
	endtask
	// ****************************************
	// scenarios
	// ****************************************
	task automatic t_regs();
		axi_rd(trs_pkg::OFF_BUFSZ, rd, rp);
		chk(rd, {24'h000000, trs_pkg::BUFSZ_RST});
		axi_rd(8'h40, rd, rp);
		chk({30'h0, rp}, {30'h0, trs_pkg::RESP_SLVERR});
		axi_wr(trs_pkg::OFF_CTRL, 32'h0000000E);
		axi_rd(trs_pkg::OFF_CTRL, rd, rp);
		chk(rd, 32'h0000000E);
	endtask
	// end-of-file block; the abnormal bit is allowed either way
	task automatic t_eof(input logic [3:0] ctrl, input logic [31:0] exp);
		run(ctrl, 1, trs_pkg::EOF_PATTERN, 8'h03);
		chk(st & 32'h00FF01F7, exp);
		chk({29'h0, rs[7:5]}, {29'h0, trs_pkg::C_EOF});
		chk({29'h0, rs[4:2]}, {29'h0, trs_pkg::A_REPORT_EOF});
	endtask
	task automatic t_noise(input logic [3:0] ctrl, input logic [2:0] act);
		run(ctrl, 1, 9'h0A5, 8'h03);
		chk(st & 32'h00FF01F7, 32'h00000002);
		chk({29'h0, rs[7:5]}, {29'h0, trs_pkg::C_PAR});
		chk({29'h0, rs[4:2]}, {29'h0, act});
	endtask
	task automatic t_short();
		logic [31:0] w;
		run(4'h7, 10, 9'h000, 8'h03);
		chk(st & 32'h00FF01FF, 32'h00030148);
		chk({30'h0, rs[9:8]}, {30'h0, trs_pkg::LEN_MID});
		chk({29'h0, rs[7:5]}, {29'h0, trs_pkg::C_M15});
		chk({29'h0, rs[4:2]}, {29'h0, trs_pkg::A_REPORT_ABN});
		for (int k = 0; k < 3; k++) begin
			for (int j = 0; j < 4; j++) w[31-8*j -: 8] = (4*k+j < 10) ? 8'(16+4*k+j) : 8'h00;
			axi_rd(trs_pkg::OFF_DATA, rd, rp);
			chk(rd, w);
		end
	endtask
	task automatic t_full();
		run(4'h7, 15, 9'h000, 8'h08);
		chk(st & 32'h00FF01FF, 32'h00040000);
		chk({30'h0, rs[9:8]}, {30'h0, trs_pkg::LEN_LONG});
	endtask
	task automatic t_late();
		run(4'h7, 14, 9'h000, 8'h03);
		chk(st & 32'h00FF01FF, 32'h0003000C);
		chk({29'h0, rs[7:5]}, {29'h0, trs_pkg::C_LATE});
	endtask
	task automatic t_par(input logic [3:0] ctrl, input int len, input logic [7:0] bsz);
		lrc_ok <= 1'b0;
		run(ctrl, len, 9'h000, bsz);
		lrc_ok <= 1'b1;
		chk({31'h0, st[1]}, 32'h00000001);
		chk({29'h0, rs[7:5]}, {29'h0, trs_pkg::C_PAR});
		chk({29'h0, rs[4:2]}, {29'h0, trs_pkg::A_REPOS});
		chk({30'h0, rs[11:10]}, 32'(trs_pkg::RETRY_MAX));
	endtask
	initial begin
		repeat (16) @(posedge clk);
		rst_b <= 1'b1;
		t_regs();
		t_eof(4'h7, 32'h00000001);
		t_eof(4'h5, 32'h00000003);
		t_noise(4'hB, trs_pkg::A_NONE);
		t_noise(4'h3, trs_pkg::A_RETRY);
		t_short();
		t_full();
		t_late();
		t_par(4'h7, 15, 8'h08);
		t_par(4'h3, 14, 8'h03);
		stop_test();
	end
endmodule
`default_nettype wire
